// File: rtl/sms_pkg.sv
// Behaviour
// - Protected page refuses every programming attempt.
// - Protected page stays readable, never altered.
// - Upper location-zero bits are software flags only.
// - Redirection bytes stored, never steer hardware.
// - Programming only clears bits, except location seven, which it overwrites.
// - Redirection upper six bits stay one.
// - Location five holds fixed test value.
// - Location six returns fixed distinguishing value.
// - Location seven bits zero-four hold search settings.
// - Location seven bits five-six are channel flip-flops.
// - Search settings and channels reset to ones.
// - Channel zero turns open-drain transistor on.
// - Location seven bit seven shows supply.
// - Master opens with command and two bytes.
// - Writes go byte-wise through scratchpad, program pulse.
// - Every byte travels least significant bit first.
// - Read command takes low then high address.
// - Master sends high byte and bit seven zero.
// - Read slots stream data until field end.
// - Field end gives CRC over command, address, data.
// - After the CRC, read slots return ones.
// - Reset pulse aborts read, no early CRC.
package sms_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0] CMD_READ_MEM   = 8'hf0;
    localparam logic [7:0] CMD_READ_STAT  = 8'haa;
    localparam logic [7:0] CMD_WRITE_MEM  = 8'h0f;
    localparam logic [7:0] CMD_WRITE_STAT = 8'h55;

    // ****************************************
    // Memory map
    // ****************************************
    localparam int         MEM_BYTES      = 128;
    localparam logic [6:0] MEM_LAST       = 7'h7f;
    localparam logic [2:0] STAT_LAST      = 3'h7;
    localparam logic [2:0] ST_PROTECT     = 3'h0;
    localparam logic [2:0] ST_REDIR_LO    = 3'h1;
    localparam logic [2:0] ST_REDIR_HI    = 3'h4;
    localparam logic [2:0] ST_TEST        = 3'h5;
    localparam logic [2:0] ST_DISTINGUISH = 3'h6;
    localparam logic [2:0] ST_SEARCH      = 3'h7;
    localparam logic [7:0] EPROM_ERASED   = 8'hff;
    localparam logic [7:0] REDIR_KEEP     = 8'hfc;
    localparam logic [4:0] SEARCH_RESET   = 5'h1f;
    localparam logic [1:0] CHAN_RESET     = 2'h3;
    localparam logic [7:0] TEST_VALUE     = 8'h00;
    // Arbitrary value, chosen only to tell this part from its sibling.
    localparam logic [7:0] DISTINGUISH_VALUE = 8'h5a;

    // ****************************************
    // CRC
    // ****************************************
    localparam logic [15:0] CRC_POLY_REFL = 16'ha001;

    // ****************************************
    // Controller registers and operations
    // ****************************************
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CRC    = 4'h8;
    localparam int         CTRL_OP_LSB = 8;
    localparam int         STAT_BUSY   = 8;
    localparam logic [1:0] OP_RESET   = 2'h0;
    localparam logic [1:0] OP_WRITE   = 2'h1;
    localparam logic [1:0] OP_READ    = 2'h2;
    localparam logic [1:0] OP_PROGRAM = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_SLOT_NS     = 200;
    localparam int T_RESET_NS    = 480000;
    localparam int T_PROG_NS     = 480000;
    localparam int SLOT_CYC  = (T_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYC = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CYC  = (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// File: rtl/sms_link_if.sv
`timescale 1ns/1ps
// Slot-level view of the single-wire link, both ends on one clock.
interface sms_link_if;
    logic slot_stb;
    logic slot_rd;
    logic wr_bit;
    logic rst_pulse;
    logic prog_pulse;
    logic rd_bit;

    modport mst (
        output slot_stb,
        output slot_rd,
        output wr_bit,
        output rst_pulse,
        output prog_pulse,
        input  rd_bit
    );

    modport dev (
        input  slot_stb,
        input  slot_rd,
        input  wr_bit,
        input  rst_pulse,
        input  prog_pulse,
        output rd_bit
    );
endinterface

// File: rtl/sms_crc16.sv
`timescale 1ns/1ps
module sms_crc16
    import sms_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Control
    input  wire logic        clr,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    input  wire logic        en,
    input  wire logic        bit_in,
    // Result
    output logic      [15:0] crc
);

    logic [15:0] crc_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crc_ff <= 16'h0000;
        end else if (clr) begin
            crc_ff <= 16'h0000;
        end else if (load) begin
            crc_ff <= load_val;
        end else if (en) begin
            // Reflected form, so bits enter least significant first.
            crc_ff <= (crc_ff >> 1) ^ ((crc_ff[0] ^ bit_in) ? CRC_POLY_REFL : 16'h0000);
        end
    end

    assign crc = crc_ff;

endmodule // sms_crc16

// File: rtl/sms_switch_dev.sv
`timescale 1ns/1ps
module sms_switch_dev
    import sms_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Link
    sms_link_if.dev         lnk,
    // Supply sense pin
    input  wire logic       supply_pin,
    // Open-drain channels
    output logic      [1:0] open_drain_output_out,
    output logic      [1:0] open_drain_output_oe
);

    typedef enum logic [3:0] {
        D_IDLE, D_CMD, D_ALO, D_AHI, D_RDAT, D_RCRC, D_ONES,
        D_WDAT, D_WCRC, D_WPROG, D_WVER
    } sms_dstate_e;

    sms_dstate_e state_ff;
    logic [7:0]  cmd_ff;
    logic [15:0] addr_ff;
    logic [7:0]  sh_ff;
    logic [7:0]  scratch_ff;
    logic [3:0]  cnt_ff;
    logic        rd_bit_ff;
    logic        prog_q_ff;
    logic [7:0]  mem_ff [MEM_BYTES];
    logic [7:0]  stat_ff [5];
    logic [4:0]  search_ff;
    logic [1:0]  chan_ff;
    logic        sup_s1_ff;
    logic        sup_s2_ff;
    logic [1:0]  od_oe_ff;
    logic [1:0]  od_out_ff;

    logic        wslot;
    logic        rslot;
    logic [7:0]  rx_byte;
    logic        is_stat;
    logic        is_read;
    logic        is_write;
    logic [7:0]  cur_byte;
    logic        at_end;
    logic        prog_go;
    logic        crc_en;
    logic        crc_bit;
    logic        crc_load;
    logic [15:0] crc;
    logic [15:0] nxt_addr;

    // ****************************************
    // Decode
    // ****************************************
    assign wslot    = lnk.slot_stb & ~lnk.slot_rd;
    assign rslot    = lnk.slot_stb & lnk.slot_rd;
    assign rx_byte  = {lnk.wr_bit, sh_ff[7:1]};
    assign is_stat  = (cmd_ff == CMD_READ_STAT) || (cmd_ff == CMD_WRITE_STAT);
    assign is_read  = (cmd_ff == CMD_READ_MEM) || (cmd_ff == CMD_READ_STAT);
    assign is_write = (cmd_ff == CMD_WRITE_MEM) || (cmd_ff == CMD_WRITE_STAT);
    assign at_end   = is_stat ? (addr_ff[2:0] == STAT_LAST) : (addr_ff[6:0] == MEM_LAST);
    assign nxt_addr = addr_ff + 16'h0001;
    assign prog_go  = (state_ff == D_WPROG) && lnk.prog_pulse && !prog_q_ff;

    // Redirection bytes are only returned here, never used for addressing.
    always_comb begin
        cur_byte = mem_ff[addr_ff[6:0]];
        if (is_stat) begin
            case (addr_ff[2:0])
                ST_TEST:        cur_byte = TEST_VALUE;
                ST_DISTINGUISH: cur_byte = DISTINGUISH_VALUE;
                ST_SEARCH:      cur_byte = {sup_s2_ff, chan_ff, search_ff};
                default:        cur_byte = stat_ff[addr_ff[2:0]];
            endcase
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= D_IDLE;
            cmd_ff     <= 8'h00;
            addr_ff    <= 16'h0000;
            sh_ff      <= 8'h00;
            scratch_ff <= 8'h00;
            cnt_ff     <= 4'h0;
            rd_bit_ff  <= 1'b1;
        end else if (lnk.rst_pulse) begin
            state_ff <= D_CMD;
            cnt_ff   <= 4'h0;
        end else begin
            if (rslot) begin
                rd_bit_ff <= 1'b1;
            end
            case (state_ff)
                D_CMD, D_ALO, D_AHI, D_WDAT: begin
                    if (wslot) begin
                        sh_ff  <= rx_byte;
                        cnt_ff <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'h7) begin
                            cnt_ff <= 4'h0;
                            case (state_ff)
                                D_CMD: begin
                                    cmd_ff   <= rx_byte;
                                    state_ff <= D_ALO;
                                end
                                D_ALO: begin
                                    addr_ff[7:0] <= rx_byte;
                                    state_ff     <= D_AHI;
                                end
                                D_AHI: begin
                                    addr_ff[15:8] <= rx_byte;
                                    state_ff <= is_read ? D_RDAT : (is_write ? D_WDAT : D_IDLE);
                                end
                                default: begin
                                    scratch_ff <= rx_byte;
                                    state_ff   <= D_WCRC;
                                end
                            endcase
                        end
                    end
                end
                D_RDAT, D_WVER: begin
                    if (rslot) begin
                        rd_bit_ff <= cur_byte[cnt_ff[2:0]];
                        cnt_ff    <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'h7) begin
                            cnt_ff <= 4'h0;
                            if (state_ff == D_WVER) begin
                                addr_ff  <= nxt_addr;
                                state_ff <= D_WDAT;
                            end else if (at_end) begin
                                state_ff <= D_RCRC;
                            end else begin
                                addr_ff <= nxt_addr;
                            end
                        end
                    end
                end
                D_RCRC, D_WCRC: begin
                    if (rslot) begin
                        rd_bit_ff <= crc[cnt_ff];
                        cnt_ff    <= cnt_ff + 4'h1;
                        if (cnt_ff == 4'hf) begin
                            state_ff <= (state_ff == D_RCRC) ? D_ONES : D_WPROG;
                        end
                    end
                end
                D_WPROG: begin
                    if (prog_go) begin
                        cnt_ff   <= 4'h0;
                        state_ff <= D_WVER;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prog_q_ff <= 1'b0;
        end else begin
            prog_q_ff <= lnk.prog_pulse;
        end
    end

    // ****************************************
    // CRC over command, address and data
    // ****************************************
    always_comb begin
        crc_en  = 1'b0;
        crc_bit = lnk.wr_bit;
        case (state_ff)
            D_CMD, D_ALO, D_AHI, D_WDAT: crc_en = wslot;
            D_RDAT: begin
                crc_en  = rslot;
                crc_bit = cur_byte[cnt_ff[2:0]];
            end
            default: crc_en = 1'b0;
        endcase
    end

    // Each later write pass restarts the CRC from the incremented address.
    assign crc_load = (state_ff == D_WVER) && rslot && (cnt_ff == 4'h7);

    sms_crc16 u_crc (
        .clk      (clk),
        .rstn     (rstn),
        .clr      (lnk.rst_pulse),
        .load     (crc_load),
        .load_val (nxt_addr),
        .en       (crc_en & ~lnk.rst_pulse),
        .bit_in   (crc_bit),
        .crc      (crc)
    );

    // ****************************************
    // Nonvolatile data field
    // ****************************************
    // A reset restores the erased image; a real part would keep it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
                mem_ff[i] <= EPROM_ERASED;
            end
        end else if (prog_go && !is_stat) begin
            if (stat_ff[ST_PROTECT][addr_ff[6:5]]) begin
                mem_ff[addr_ff[6:0]] <= mem_ff[addr_ff[6:0]] & scratch_ff;
            end
        end
    end

    // ****************************************
    // Status memory
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 5; i++) begin
                stat_ff[i] <= EPROM_ERASED;
            end
        end else if (prog_go && is_stat) begin
            if (addr_ff[2:0] == ST_PROTECT) begin
                // Upper nibble is stored only and feeds no logic.
                stat_ff[ST_PROTECT] <= stat_ff[ST_PROTECT] & scratch_ff;
            end else if (addr_ff[2:0] <= ST_REDIR_HI) begin
                stat_ff[addr_ff[2:0]] <= stat_ff[addr_ff[2:0]] & (scratch_ff | REDIR_KEEP);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            search_ff <= SEARCH_RESET;
            chan_ff   <= CHAN_RESET;
        end else if (prog_go && is_stat && (addr_ff[2:0] == ST_SEARCH)) begin
            search_ff <= scratch_ff[4:0];
            chan_ff   <= scratch_ff[6:5];
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sup_s1_ff <= 1'b0;
            sup_s2_ff <= 1'b0;
        end else begin
            sup_s1_ff <= supply_pin;
            sup_s2_ff <= sup_s1_ff;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            od_oe_ff  <= 2'b00;
            od_out_ff <= 2'b00;
        end else begin
            od_oe_ff  <= ~chan_ff;
            od_out_ff <= 2'b00;
        end
    end

    assign lnk.rd_bit            = rd_bit_ff;
    assign open_drain_output_oe  = od_oe_ff;
    assign open_drain_output_out = od_out_ff;

endmodule // sms_switch_dev

// File: rtl/sms_link_master.sv
`timescale 1ns/1ps
module sms_link_master
    import sms_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_CYC,
    parameter int PROG_CYCLES  = PROG_CYC,
    parameter int SLOT_CYCLES  = SLOT_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Link
    sms_link_if.mst          lnk,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata
);

    typedef enum logic [1:0] {M_IDLE, M_TIMED, M_BYTE} sms_mstate_e;

    sms_mstate_e state_ff;
    logic        reading_ff;
    logic [7:0]  sh_ff;
    logic [7:0]  rx_ff;
    logic [3:0]  cnt_ff;
    logic [16:0] tmr_ff;
    logic [7:0]  div_ff;
    logic        stb_ff;
    logic        srd_ff;
    logic        wbit_ff;
    logic        rstp_ff;
    logic        prog_ff;
    logic        cap_ff;
    logic [31:0] rdata_ff;
    logic        slot_en;
    logic        start;
    logic [1:0]  op;
    logic [15:0] crc;

    assign op      = reg_wdata[CTRL_OP_LSB +: 2];
    assign start   = reg_wr && (reg_addr == REG_CTRL) && (state_ff == M_IDLE);
    assign slot_en = (div_ff == 8'h00);

    // ****************************************
    // Slot divider
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= 8'h00;
        end else if (slot_en) begin
            div_ff <= 8'(SLOT_CYCLES - 1);
        end else begin
            div_ff <= div_ff - 8'h01;
        end
    end

    // ****************************************
    // Operation engine
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff   <= M_IDLE;
            reading_ff <= 1'b0;
            sh_ff      <= 8'h00;
            rx_ff      <= 8'h00;
            cnt_ff     <= 4'h0;
            tmr_ff     <= 17'h00000;
            stb_ff     <= 1'b0;
            srd_ff     <= 1'b0;
            wbit_ff    <= 1'b0;
            rstp_ff    <= 1'b0;
            prog_ff    <= 1'b0;
            cap_ff     <= 1'b0;
        end else begin
            stb_ff <= 1'b0;
            cap_ff <= stb_ff & srd_ff;
            case (state_ff)
                M_IDLE: begin
                    if (start) begin
                        cnt_ff     <= 4'h0;
                        sh_ff      <= reg_wdata[7:0];
                        reading_ff <= (op == OP_READ);
                        if (op == OP_RESET || op == OP_PROGRAM) begin
                            rstp_ff  <= (op == OP_RESET);
                            prog_ff  <= (op == OP_PROGRAM);
                            tmr_ff   <= (op == OP_RESET) ? 17'(RESET_CYCLES - 1)
                                                         : 17'(PROG_CYCLES - 1);
                            state_ff <= M_TIMED;
                        end else begin
                            state_ff <= M_BYTE;
                        end
                    end
                end
                M_TIMED: begin
                    tmr_ff <= tmr_ff - 17'h00001;
                    if (tmr_ff == 17'h00000) begin
                        rstp_ff  <= 1'b0;
                        prog_ff  <= 1'b0;
                        state_ff <= M_IDLE;
                    end
                end
                M_BYTE: begin
                    if (slot_en && cnt_ff != 4'h8) begin
                        stb_ff  <= 1'b1;
                        srd_ff  <= reading_ff;
                        wbit_ff <= sh_ff[0];
                        cnt_ff  <= cnt_ff + 4'h1;
                        if (!reading_ff) begin
                            sh_ff <= {1'b1, sh_ff[7:1]};
                        end
                    end
                    if (cap_ff) begin
                        sh_ff <= {lnk.rd_bit, sh_ff[7:1]};
                    end
                    if (cnt_ff == 4'h8 && !stb_ff && !cap_ff) begin
                        rx_ff    <= sh_ff;
                        state_ff <= M_IDLE;
                    end
                end
                default: state_ff <= M_IDLE;
            endcase
        end
    end

    // Software checks its own copy against the one the device sends.
    sms_crc16 u_crc (
        .clk      (clk),
        .rstn     (rstn),
        .clr      (reg_wr && (reg_addr == REG_CRC)),
        .load     (1'b0),
        .load_val (16'h0000),
        .en       ((stb_ff & ~srd_ff) | cap_ff),
        .bit_in   (cap_ff ? lnk.rd_bit : wbit_ff),
        .crc      (crc)
    );

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_STATUS: rdata_ff <= {23'h000000, state_ff != M_IDLE, rx_ff};
                REG_CRC:    rdata_ff <= {16'h0000, crc};
                default:    rdata_ff <= 32'h00000000;
            endcase
        end else begin
            rdata_ff <= 32'h00000000;
        end
    end

    assign lnk.slot_stb   = stb_ff;
    assign lnk.slot_rd    = srd_ff;
    assign lnk.wr_bit     = wbit_ff;
    assign lnk.rst_pulse  = rstp_ff;
    assign lnk.prog_pulse = prog_ff;
    assign reg_rdata      = rdata_ff;

endmodule // sms_link_master

// File: tb/sms_link_checker.sv
`timescale 1ns/1ps
module sms_link_checker #(
    parameter int RESET_CYCLES = 20,
    parameter int PROG_CYCLES  = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Link signals
    input wire logic slot_stb,
    input wire logic slot_rd,
    input wire logic wr_bit,
    input wire logic rst_pulse,
    input wire logic prog_pulse,
    input wire logic rd_bit
);
    logic [15:0] rst_cnt_ff;
    logic [15:0] prog_cnt_ff;

    // Pulse lengths are counted, since a repetition of twenty cycles is too costly to unroll.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rst_cnt_ff <= 16'h0000;
        else rst_cnt_ff <= rst_pulse ? rst_cnt_ff + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) prog_cnt_ff <= 16'h0000;
        else prog_cnt_ff <= prog_pulse ? prog_cnt_ff + 16'h0001 : 16'h0000;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    stb_pulse_a: assert property (slot_stb |=> !slot_stb [*3])
        else $error("slot strobe longer than one cycle");
    stb_quiet_a: assert property (slot_stb |-> !rst_pulse && !prog_pulse)
        else $error("slot during a reset or program pulse");
    pulse_excl_a: assert property (!(rst_pulse && prog_pulse))
        else $error("reset and program pulse together");
    rst_len_a: assert property ($fell(rst_pulse) |-> rst_cnt_ff == 16'(RESET_CYCLES))
        else $error("reset pulse length wrong");
    prog_len_a: assert property ($fell(prog_pulse) |-> prog_cnt_ff == 16'(PROG_CYCLES))
        else $error("program pulse length wrong");
    rd_hold_a: assert property (!$past(slot_stb && slot_rd) |-> $stable(rd_bit))
        else $error("answer bit moved without a read slot");
    rd_fall_a: assert property ($fell(rd_bit) |-> $past(slot_rd))
        else $error("answer bit fell after a write slot");
    rd_rise_a: assert property ($rose(rd_bit) |-> $past(slot_stb))
        else $error("answer bit rose without a slot");
endmodule // sms_link_checker

// File: tb/status_memory_and_read_memory_test.sv
`timescale 1ns/1ps
module status_memory_and_read_memory_test;
    import sms_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        supply_pin = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic [1:0]  od_out, od_oe;
    logic [7:0]  sh_ff = 8'h00;
    logic [7:0]  mem [128];
    logic [7:0]  st_row [8];
    logic [15:0] crc;
    int          bad_count = 0;
    int          n_tests = 0;

    always #5 clk = ~clk;
    sms_link_if sms_link_if_i ();
    sms_switch_dev sms_switch_dev_i (.clk(clk), .rstn(rstn), .lnk(sms_link_if_i.dev),
        .supply_pin(supply_pin), .open_drain_output_out(od_out), .open_drain_output_oe(od_oe));
    sms_link_master #(.RESET_CYCLES(20), .PROG_CYCLES(20), .SLOT_CYCLES(8)) sms_link_master_i (
        .clk(clk), .rstn(rstn), .lnk(sms_link_if_i.mst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    sms_link_checker #(.RESET_CYCLES(20), .PROG_CYCLES(20)) sms_link_checker_i (.clk(clk),
        .rstn(rstn), .slot_stb(sms_link_if_i.slot_stb), .slot_rd(sms_link_if_i.slot_rd),
        .wr_bit(sms_link_if_i.wr_bit), .rst_pulse(sms_link_if_i.rst_pulse),
        .prog_pulse(sms_link_if_i.prog_pulse), .rd_bit(sms_link_if_i.rd_bit));

    // Captures write slots off the wire, shifting in from the top so LSB-first lands in place.
    always @(posedge clk) if (sms_link_if_i.slot_stb && !sms_link_if_i.slot_rd)
        sh_ff <= {sms_link_if_i.wr_bit, sh_ff[7:1]};

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
        for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
        return c;
    endfunction
    task automatic reg_op(input logic [3:0] a, input logic [31:0] d, input logic w);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic op(input logic [1:0] o, input logic [7:0] d);
        reg_op(REG_CTRL, {22'h0, o, d}, 1'b1);
        rv = 32'h100;
        for (int i = 0; i < 500 && rv[STAT_BUSY] !== 1'b0; i++) reg_op(REG_STATUS, 32'h0, 1'b0);
        if (rv[STAT_BUSY] !== 1'b0) bad_count++;
    endtask
    task automatic sendb(input logic [7:0] d);
        op(OP_WRITE, d);
        crc = crc8(crc, d);
        check(sh_ff, d);
    endtask
    task automatic getb(input logic [7:0] exp);
        op(OP_READ, 8'h00);
        check(rv[7:0], exp);
    endtask
    task automatic start(input logic [7:0] cmd, input logic [7:0] a);
        op(OP_RESET, 8'h00);
        reg_op(REG_CRC, 32'h0, 1'b1);
        crc = 16'h0000;
        sendb(cmd);
        sendb(a);
        sendb(8'h00);
    endtask
    task automatic chk_crc;
        logic [15:0] c;
        c = crc;
        getb(c[7:0]);
        getb(c[15:8]);
    endtask
    task automatic wr_byte(input logic [7:0] cmd, a, d, exp);
        start(cmd, a);
        sendb(d);
        chk_crc();
        op(OP_PROGRAM, 8'h00);
        getb(exp);
    endtask

    initial begin
        #900us;
        bad_count++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 8'hff;
        st_row = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, TEST_VALUE, DISTINGUISH_VALUE,
                   {1'b1, CHAN_RESET, SEARCH_RESET}};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        start(CMD_READ_STAT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            crc = crc8(crc, st_row[i]);
            getb(st_row[i]);
        end
        chk_crc();
        getb(8'hff);
        check(od_oe, 2'b00);
        wr_byte(CMD_WRITE_MEM, 8'h03, 8'ha5, 8'ha5);
        wr_byte(CMD_WRITE_MEM, 8'h03, 8'h5a, 8'h00);
        mem[3] = 8'h00;
        wr_byte(CMD_WRITE_STAT, 8'h00, 8'hed, 8'hed);
        wr_byte(CMD_WRITE_MEM, 8'h23, 8'h00, 8'hff);
        wr_byte(CMD_WRITE_MEM, 8'h04, 8'h3c, 8'h3c);
        mem[4] = 8'h3c;
        crc = 16'h0005;
        sendb(8'h96);
        chk_crc();
        op(OP_PROGRAM, 8'h00);
        getb(8'h96);
        mem[5] = 8'h96;
        wr_byte(CMD_WRITE_STAT, 8'h01, 8'h00, REDIR_KEEP);
        wr_byte(CMD_WRITE_STAT, 8'h07, 8'hdf, 8'hdf);
        check(od_oe, 2'b01);
        @(posedge clk) supply_pin <= 1'b0;
        start(CMD_READ_STAT, 8'h07);
        getb(8'h5f);
        start(CMD_READ_MEM, 8'h00);
        for (int i = 0; i < 128; i++) begin
            crc = crc8(crc, mem[i]);
            getb(mem[i]);
        end
        chk_crc();
        getb(8'hff);
        start(CMD_READ_MEM, 8'h7e);
        getb(mem[126]);
        start(CMD_READ_MEM, 8'h7f);
        crc = crc8(crc, mem[127]);
        getb(mem[127]);
        reg_op(REG_CRC, 32'h0, 1'b0);
        check(rv, {16'h0000, crc});
        chk_crc();
        reg_op(REG_CRC, 32'h0, 1'b0);
        check(rv, 32'h0);
        close_out();
    end
endmodule // status_memory_and_read_memory_test
